// ===== ssh_pkg.sv
package ssh_pkg;

   // Widths
   localparam int SSH_DIV_W   = 10;
   localparam int SSH_SHIFT_W = 16;
   localparam int SSH_BYTE_W  = 8;
   localparam int SSH_CNT_W   = 4;

   // Last bit index per transfer length
   localparam logic [SSH_CNT_W-1:0] SSH_LAST_BIT_8  = 4'h7;
   localparam logic [SSH_CNT_W-1:0] SSH_LAST_BIT_16 = 4'hF;

   // Reset values
   localparam logic                    SSH_MODE_HI_RST    = 1'b0;
   localparam logic                    SSH_MODE_LO_RST    = 1'b0;
   localparam logic                    SSH_CLK_SRC_RST    = 1'b0;
   localparam logic [2:0]              SSH_PRESCALE_RST   = 3'h0;
   localparam logic                    SSH_IDLE_LEVEL_RST = 1'b0;
   localparam logic [SSH_SHIFT_W-1:0]  SSH_SHIFT_RST      = 16'h0000;
   localparam logic [SSH_CNT_W-1:0]    SSH_COUNT_RST      = 4'h0;
   localparam logic [SSH_DIV_W-1:0]    SSH_DIV_RST        = 10'h000;

   // Channel sequencing
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_WAIT = 3'h2,
      ST_RUN  = 3'h4
   } ssh_state_t;

   // Prescaler tap bit: phi/1024 down to phi/2
   function automatic logic [3:0] ssh_tap(input logic [2:0] sel);
      case (sel)
         3'h0:    ssh_tap = 4'h9;
         3'h1:    ssh_tap = 4'h7;
         3'h2:    ssh_tap = 4'h5;
         3'h3:    ssh_tap = 4'h4;
         3'h4:    ssh_tap = 4'h3;
         3'h5:    ssh_tap = 4'h2;
         3'h6:    ssh_tap = 4'h1;
         default: ssh_tap = 4'h0;
      endcase
   endfunction

   // Mask of counter bits below the tap
   function automatic logic [SSH_DIV_W-1:0] ssh_low_mask(input logic [3:0] tap);
      ssh_low_mask = (10'h001 << tap) - 10'h001;
   endfunction

endpackage

// ===== ssh_prescaler.sv
`timescale 1ns/1ps
module ssh_prescaler
   import ssh_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Control
   input  wire logic       clear,
   input  wire logic [2:0] sel,
   // Serial clock edge ticks
   output logic            tick_fall,
   output logic            tick_rise
);

   logic [SSH_DIV_W-1:0] count;
   logic [SSH_DIV_W-1:0] next_count;
   logic [SSH_DIV_W-1:0] mask;
   logic [3:0]           tap;
   logic                 low_full;

   // Free running divider; tap bit is the serial clock level
   always_comb begin
      tap        = ssh_tap(sel);
      mask       = ssh_low_mask(tap);
      low_full   = (count & mask) == mask;
      next_count = clear ? SSH_DIV_RST : count + 10'h001;
      // Ticks mark the edge at which the tap bit flips
      tick_fall  = low_full && count[tap] && !clear;
      tick_rise  = low_full && !count[tap] && !clear;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= SSH_DIV_RST;
      end else begin
         count <= next_count;
      end
   end

endmodule

// ===== ssh_shifter.sv
`timescale 1ns/1ps
// Function
// R1: Words shift least significant bit first, both directions.
// R2: Serial output changes on each serial clock falling edge, held until next.
// R3: Serial input is sampled on each serial clock rising edge.
// R4: With upper mode bit clear, lower mode bit picks 8 or 16 bits.
// R5: Any control write resets bit counter and sequencing.
// R6: 8-bit uses low byte only; 16-bit uses high and low bytes.
// R7: Writing start flag begins shifting the loaded word out.
// R8: Received bits shift into data bytes, readable after completion.
// R9: Simultaneous mode sends and receives in one clock sequence.
// R10: Completion sets the transfer done request flag.
// R11: Done request reaches processor only while its enable is set.
// R12: Internal clock pulses only during transfer, stopped until next start.
// R13: After completion the output keeps the last bit shifted out.
// R14: External source shifts on received clock pulses, none generated.
// R15: External pulses after completion shift nothing and set overrun flag.
// R16: Idle-level write while stopped sets the output pin immediately.
// R17: Peer must wait for start flag before supplying external clock.
// R18: Pins act only when their function bits are set; optional open drain.
// R19: Start flag reads one while waiting and running, clears at completion.
// R20: Overrun clears only by writing zero after reading it as one.
// R21: Clock source picks prescaler or external; three bits pick division.
// R22: Mode bits 10 drive the selected internal clock continuously.
// R23: Completion after exactly 8 or 16 bits as selected.
// R24: Sampled bit enters at top of shift path while LSB leaves.
module ssh_shifter
   import ssh_pkg::*;
(
   // Clock and reset
   input  wire logic       CLK,
   input  wire logic       RESET_N,
   // Control register write
   input  wire logic       CTRL_WR,
   input  wire logic       MODE_SELECT_HI,
   input  wire logic       MODE_SELECT_LO,
   input  wire logic       CLOCK_SOURCE_SELECT,
   input  wire logic [2:0] PRESCALE_SELECT,
   // Status register access
   input  wire logic       START_WR,
   input  wire logic       IDLE_LEVEL_WR,
   input  wire logic       IDLE_LEVEL_DATA,
   input  wire logic       OVERRUN_RD,
   input  wire logic       OVERRUN_CLR_WR,
   output logic            START_BUSY_FLAG,
   output logic            OVERRUN_FLAG,
   output logic            IDLE_LEVEL_BIT,
   // Shift data bytes
   input  wire logic       LOW_SHIFT_WR,
   input  wire logic       HIGH_SHIFT_WR,
   input  wire logic [7:0] SHIFT_WR_DATA,
   output logic [7:0]      LOW_SHIFT_BYTE,
   output logic [7:0]      HIGH_SHIFT_BYTE,
   // Interrupt request
   input  wire logic       TRANSFER_DONE_CLR_WR,
   input  wire logic       TRANSFER_DONE_IRQ_ENABLE,
   output logic            TRANSFER_DONE_REQUEST,
   output logic            TRANSFER_DONE_IRQ,
   // Pin function
   input  wire logic       PIN_CLOCK_FUNC,
   input  wire logic       PIN_IN_FUNC,
   input  wire logic       PIN_OUT_FUNC,
   input  wire logic       OPEN_DRAIN_SELECT,
   // Serial pins
   input  wire logic       SERIAL_CLOCK_PIN_I,
   output logic            SERIAL_CLOCK_PIN_O,
   output logic            SERIAL_CLOCK_PIN_OE_N,
   input  wire logic       SERIAL_IN_PIN_I,
   output logic            SERIAL_OUT_PIN_O,
   output logic            SERIAL_OUT_PIN_OE_N
);

   logic                   rst_meta;
   logic                   rst_n;
   logic                   sck_meta;
   logic                   sck_sync;
   logic                   sck_prev;
   logic                   si_meta;
   logic                   si_sync;
   logic                   sck_eff;
   logic                   si_bit;
   logic                   ext_fall;
   logic                   ext_rise;
   logic                   div_fall;
   logic                   div_rise;
   logic                   edge_fall;
   logic                   edge_rise;
   logic                   mode_hi;
   logic                   mode_lo;
   logic                   clk_ext;
   logic [2:0]             prescale;
   logic                   next_mode_hi;
   logic                   next_mode_lo;
   logic                   next_clk_ext;
   logic [2:0]             next_prescale;
   logic                   len16;
   logic                   continuous;
   logic [SSH_CNT_W-1:0]   last_bit;
   ssh_state_t             state;
   ssh_state_t             next_state;
   logic [SSH_CNT_W-1:0]   bit_count;
   logic [SSH_CNT_W-1:0]   next_bit_count;
   logic [SSH_SHIFT_W-1:0] shift;
   logic [SSH_SHIFT_W-1:0] next_shift;
   logic                   so_level;
   logic                   next_so_level;
   logic                   sck_level;
   logic                   next_sck_level;
   logic                   finished;
   logic                   next_finished;
   logic                   done_evt;
   logic                   ovr_evt;
   logic                   done_req;
   logic                   next_done_req;
   logic                   overrun;
   logic                   next_overrun;
   logic                   ovr_armed;
   logic                   next_ovr_armed;

   // Reset release through two flops
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Pin synchronisers; sck_prev only looks at the second stage
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         sck_meta <= 1'b1;
         sck_sync <= 1'b1;
         sck_prev <= 1'b1;
         si_meta  <= 1'b1;
         si_sync  <= 1'b1;
      end else begin
         sck_meta <= SERIAL_CLOCK_PIN_I;
         sck_sync <= sck_meta;
         sck_prev <= sck_eff;
         si_meta  <= SERIAL_IN_PIN_I;
         si_sync  <= si_meta;
      end
   end

   // Pin functions gate the inputs; unused pins look idle high
   assign sck_eff  = PIN_CLOCK_FUNC ? sck_sync : 1'b1; // R18
   assign si_bit   = PIN_IN_FUNC ? si_sync : 1'b1;     // R18
   assign ext_fall = sck_prev && !sck_eff;
   assign ext_rise = !sck_prev && sck_eff;

   // Divider restarts on control write so phase is known
   ssh_prescaler u_prescaler (
      .clk       (CLK),
      .rst_n     (rst_n),
      .clear     (CTRL_WR),
      .sel       (prescale),
      .tick_fall (div_fall),
      .tick_rise (div_rise)
   );

   // Edge source: own prescaler or peer clock
   assign edge_fall  = clk_ext ? ext_fall : div_fall;          // R14 R21
   assign edge_rise  = clk_ext ? ext_rise : div_rise;          // R14 R21
   assign len16      = !mode_hi && mode_lo;                    // R4
   assign continuous = mode_hi && !mode_lo && !clk_ext;        // R22
   assign last_bit   = len16 ? SSH_LAST_BIT_16 : SSH_LAST_BIT_8; // R23

   // Control register
   always_comb begin
      next_mode_hi  = mode_hi;
      next_mode_lo  = mode_lo;
      next_clk_ext  = clk_ext;
      next_prescale = prescale;
      if (CTRL_WR) begin
         next_mode_hi  = MODE_SELECT_HI;
         next_mode_lo  = MODE_SELECT_LO;
         next_clk_ext  = CLOCK_SOURCE_SELECT;
         next_prescale = PRESCALE_SELECT;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         mode_hi  <= SSH_MODE_HI_RST;
         mode_lo  <= SSH_MODE_LO_RST;
         clk_ext  <= SSH_CLK_SRC_RST;
         prescale <= SSH_PRESCALE_RST;
      end else begin
         mode_hi  <= next_mode_hi;
         mode_lo  <= next_mode_lo;
         clk_ext  <= next_clk_ext;
         prescale <= next_prescale;
      end
   end

   // Transfer sequencer, shift path and output level
   always_comb begin
      next_state     = state;
      next_bit_count = bit_count;
      next_shift     = shift;
      next_so_level  = so_level;
      next_finished  = finished;
      done_evt       = 1'b0;
      case (state)
         ST_IDLE: begin
            // Continuous clock mode carries no data
            if (START_WR && !mode_hi) begin
               next_state    = ST_WAIT; // R7 R19
               next_finished = 1'b0;
            end
            if (IDLE_LEVEL_WR) begin
               next_so_level = IDLE_LEVEL_DATA; // R16
            end
            if (LOW_SHIFT_WR) begin
               next_shift[7:0] = SHIFT_WR_DATA; // R6
            end
            if (HIGH_SHIFT_WR) begin
               next_shift[15:8] = SHIFT_WR_DATA; // R6
            end
         end
         ST_WAIT: begin
            // Armed; an external peer starts clocking only now
            if (edge_fall) begin
               next_state    = ST_RUN;   // R17
               next_so_level = shift[0]; // R1 R2
            end
         end
         ST_RUN: begin
            if (edge_fall) begin
               next_so_level = shift[0]; // R1 R2
            end
            if (edge_rise) begin
               // Sample enters at the top, word moves toward the LSB
               if (len16) begin
                  next_shift = {si_bit, shift[15:1]}; // R3 R8 R9 R24
               end else begin
                  next_shift[7:0] = {si_bit, shift[7:1]}; // R3 R8 R9 R24
               end
               if (bit_count == last_bit) begin
                  next_state     = ST_IDLE; // R19 R23
                  next_bit_count = SSH_COUNT_RST;
                  next_finished  = 1'b1;
                  done_evt       = 1'b1;    // R10
               end else begin
                  next_bit_count = bit_count + 4'h1; // R23
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      // A control write drops any transfer in flight
      if (CTRL_WR) begin
         next_state     = ST_IDLE; // R5
         next_bit_count = SSH_COUNT_RST;
         next_finished  = 1'b0;
      end
   end

   // Serial clock level; idles high between transfers
   always_comb begin
      next_sck_level = 1'b1;                                   // R12
      if (continuous || (next_state == ST_RUN && !clk_ext)) begin // R14
         next_sck_level = div_rise ? 1'b1 : (div_fall ? 1'b0 : sck_level); // R12 R22
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         state     <= ST_IDLE;
         bit_count <= SSH_COUNT_RST;
         shift     <= SSH_SHIFT_RST;
         so_level  <= SSH_IDLE_LEVEL_RST;
         finished  <= 1'b0;
         sck_level <= 1'b1;
      end else begin
         state     <= next_state;
         bit_count <= next_bit_count;
         shift     <= next_shift;
         so_level  <= next_so_level; // R13
         finished  <= next_finished;
         sck_level <= next_sck_level;
      end
   end

   // Sticky flags; a set in the clearing cycle wins
   assign ovr_evt = clk_ext && state == ST_IDLE && finished && ext_fall; // R15

   always_comb begin
      next_done_req  = done_evt || (done_req && !TRANSFER_DONE_CLR_WR);    // R10
      next_overrun   = ovr_evt || (overrun && !(OVERRUN_CLR_WR && ovr_armed)); // R15 R20
      next_ovr_armed = ovr_armed;
      if (OVERRUN_RD && overrun) begin
         next_ovr_armed = 1'b1; // R20
      end else if (OVERRUN_CLR_WR) begin
         next_ovr_armed = 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         done_req  <= 1'b0;
         overrun   <= 1'b0;
         ovr_armed <= 1'b0;
      end else begin
         done_req  <= next_done_req;
         overrun   <= next_overrun;
         ovr_armed <= next_ovr_armed;
      end
   end

   // Outputs
   assign START_BUSY_FLAG       = state != ST_IDLE; // R19
   assign OVERRUN_FLAG          = overrun;
   assign IDLE_LEVEL_BIT        = so_level;
   assign LOW_SHIFT_BYTE        = shift[7:0];
   assign HIGH_SHIFT_BYTE       = shift[15:8];
   assign TRANSFER_DONE_REQUEST = done_req;
   assign TRANSFER_DONE_IRQ     = done_req && TRANSFER_DONE_IRQ_ENABLE; // R11
   // Clock pin drives only as output of the internal source
   assign SERIAL_CLOCK_PIN_O    = sck_level;
   assign SERIAL_CLOCK_PIN_OE_N = !(PIN_CLOCK_FUNC && !clk_ext); // R18 R21
   // Open drain pulls low only, a high level floats
   assign SERIAL_OUT_PIN_O      = so_level;
   assign SERIAL_OUT_PIN_OE_N   = !(PIN_OUT_FUNC && (!OPEN_DRAIN_SELECT || !so_level)); // R18

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!rst_n);

   AST_FALL_SHIFT_OUT: assert property ( // R2
      (state != ST_IDLE && edge_fall && !CTRL_WR) |=> so_level == $past(shift[0]))
      else $error("output bit not taken from LSB on falling edge");
   AST_RISE_SAMPLE: assert property ( // R3
      (state == ST_RUN && edge_rise && !len16 && !CTRL_WR)
      |=> shift[7] == $past(si_bit) && shift[6:0] == $past(shift[7:1]))
      else $error("input bit not shifted in at top on rising edge");
   AST_CTRL_RESET: assert property ( // R5
      CTRL_WR |=> state == ST_IDLE && bit_count == SSH_COUNT_RST)
      else $error("control write did not reset transfer state");
   AST_DONE_COUNT: assert property ( // R23
      (state == ST_RUN && edge_rise && bit_count == last_bit && !CTRL_WR)
      |=> done_req && !START_BUSY_FLAG)
      else $error("completion not declared after last bit");
   AST_IRQ_GATE: assert property ( // R11
      !TRANSFER_DONE_IRQ_ENABLE |-> !TRANSFER_DONE_IRQ)
      else $error("interrupt passed while disabled");
   AST_SCK_STOPPED: assert property ( // R12
      (state == ST_IDLE && !continuous) |=> sck_level)
      else $error("serial clock pulsed outside a transfer");
   AST_LAST_BIT_HOLD: assert property ( // R13
      (state == ST_IDLE && !IDLE_LEVEL_WR) |=> $stable(so_level))
      else $error("output level moved while stopped");
   AST_IDLE_LEVEL: assert property ( // R16
      (state == ST_IDLE && IDLE_LEVEL_WR) |=> so_level == $past(IDLE_LEVEL_DATA))
      else $error("idle level write not applied");
   AST_OVERRUN: assert property ( // R15
      (ovr_evt && !LOW_SHIFT_WR && !HIGH_SHIFT_WR) |=> overrun && $stable(shift))
      else $error("overrun not flagged or data shifted");
   AST_OVR_CLEAR: assert property ( // R20
      (overrun && !ovr_armed && !OVERRUN_RD) |=> overrun)
      else $error("overrun cleared without prior read");
   AST_BUSY_SET: assert property ( // R19
      (state == ST_IDLE && START_WR && !mode_hi && !CTRL_WR) |=> START_BUSY_FLAG)
      else $error("start flag not set by start write");
   AST_PIN_OFF: assert property ( // R18
      !PIN_OUT_FUNC |-> SERIAL_OUT_PIN_OE_N)
      else $error("data pin driven while not selected");

endmodule

// ===== ssh_peer.sv
`timescale 1ns/1ps
module ssh_peer
   import ssh_pkg::*;
#(
   parameter int HALF = 8
)
(
   // System clock and device status
   input  wire logic clk,
   input  wire logic busy,
   // Serial wires
   input  wire logic sck,
   input  wire logic so,
   output logic      si,
   output logic      sck_drv,
   output logic      sck_en
);
   logic [SSH_SHIFT_W-1:0] tx_word;
   logic [SSH_SHIFT_W-1:0] rx_word;
   logic                   ext_clk;
   logic                   armed = 1'b0;
   int                     nbits;
   int                     extra;

   // Load the next frame before the device is started
   task automatic arm(input logic [15:0] tx, input int n, input logic ext, input int ex);
      tx_word = tx;
      rx_word = 16'h0000;
      nbits   = n;
      ext_clk = ext;
      extra   = ex;
      armed   = 1'b1;
   endtask

   // One frame per arm; clock stands high between frames
   initial begin
      si      = 1'b1;
      sck_drv = 1'b1;
      sck_en  = 1'b0;
      forever begin
         wait (armed === 1'b1);
         if (ext_clk) begin
            // Clocking before busy would lose the first bits
            wait (busy === 1'b1);
            sck_en = 1'b1;
            for (int i = 0; i < nbits + extra; i++) begin
               @(negedge clk);
               sck_drv = 1'b0;
               if (i < nbits) si = tx_word[i];
               repeat (HALF) @(negedge clk);
               sck_drv = 1'b1;
               if (i < nbits) rx_word[i] = so;
               repeat (HALF) @(negedge clk);
            end
            sck_en = 1'b0;
         end else begin
            for (int i = 0; i < nbits; i++) begin
               @(negedge sck);
               si = tx_word[i];
               @(posedge sck);
               rx_word[i] = so;
            end
         end
         // Hold past the device input sync, then show a stale level
         repeat (4) @(negedge clk);
         si    = ~si;
         armed = 1'b0;
      end
   end
endmodule

// ===== ssh_shifter_tb.sv
`timescale 1ns/1ps
module ssh_shifter_tb;
   import ssh_pkg::*;

   // One-hot strobe bits and prescaler divisors
   localparam logic [7:0] W_CTRL  = 8'h01;
   localparam logic [7:0] W_START = 8'h02;
   localparam logic [7:0] W_IDLE  = 8'h04;
   localparam logic [7:0] W_ORD   = 8'h08;
   localparam logic [7:0] W_OCLR  = 8'h10;
   localparam logic [7:0] W_LOW   = 8'h20;
   localparam logic [7:0] W_HIGH  = 8'h40;
   localparam logic [7:0] W_DCLR  = 8'h80;
   localparam int         DIVS [8] = '{1024, 256, 64, 32, 16, 8, 4, 2};

   // Stimulus
   logic       CLK     = 1'b0;
   logic       RESET_N = 1'b0;
   logic [7:0] stb     = 8'h00;
   logic [7:0] wr_data = 8'h00;
   logic [2:0] pre_sel = 3'h4;
   logic       mode_hi = 1'b0, mode_lo = 1'b0, clk_src = 1'b0, idle_data = 1'b0;
   logic       irq_en  = 1'b0, od_sel = 1'b0, pin_ck = 1'b1, pin_in = 1'b1, pin_out = 1'b1;
   // Device outputs and wires
   logic       busy, ovr, idle_bit, done_req, irq, sck_o, sck_oe_n, so_o, so_oe_n;
   logic [7:0] low_b, high_b;
   logic       si, peer_sck, peer_en;
   wire        sck_w, so_w;
   int         bad_count = 0, num_checks = 0, rises = 0;

   // 200 MHz clock
   always #2.5 CLK = ~CLK;

   // Pulled-up pins: released wires read high
   assign sck_w = !sck_oe_n ? sck_o : (peer_en ? peer_sck : 1'b1);
   assign so_w  = !so_oe_n ? so_o : 1'b1;
   always @(posedge sck_w) rises++;

   ssh_shifter uut (
      .CLK(CLK), .RESET_N(RESET_N), .CTRL_WR(stb[0]), .MODE_SELECT_HI(mode_hi),
      .MODE_SELECT_LO(mode_lo), .CLOCK_SOURCE_SELECT(clk_src), .PRESCALE_SELECT(pre_sel),
      .START_WR(stb[1]), .IDLE_LEVEL_WR(stb[2]), .IDLE_LEVEL_DATA(idle_data),
      .OVERRUN_RD(stb[3]), .OVERRUN_CLR_WR(stb[4]), .START_BUSY_FLAG(busy),
      .OVERRUN_FLAG(ovr), .IDLE_LEVEL_BIT(idle_bit), .LOW_SHIFT_WR(stb[5]),
      .HIGH_SHIFT_WR(stb[6]), .SHIFT_WR_DATA(wr_data), .LOW_SHIFT_BYTE(low_b),
      .HIGH_SHIFT_BYTE(high_b), .TRANSFER_DONE_CLR_WR(stb[7]),
      .TRANSFER_DONE_IRQ_ENABLE(irq_en), .TRANSFER_DONE_REQUEST(done_req),
      .TRANSFER_DONE_IRQ(irq), .PIN_CLOCK_FUNC(pin_ck), .PIN_IN_FUNC(pin_in),
      .PIN_OUT_FUNC(pin_out), .OPEN_DRAIN_SELECT(od_sel), .SERIAL_CLOCK_PIN_I(sck_w),
      .SERIAL_CLOCK_PIN_O(sck_o), .SERIAL_CLOCK_PIN_OE_N(sck_oe_n),
      .SERIAL_IN_PIN_I(si), .SERIAL_OUT_PIN_O(so_o), .SERIAL_OUT_PIN_OE_N(so_oe_n));

   ssh_peer peer (
      .clk(CLK), .busy(busy), .sck(sck_w), .so(so_w), .si(si), .sck_drv(peer_sck),
      .sck_en(peer_en));

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Compare a device value
   task automatic chkv(input logic [15:0] a, input logic [15:0] e);
      num_checks++;
      if (a !== e) begin
         bad_count++;
         $display("mismatch at %0t: value %h expected %h", $time, a, e);
      end
   endtask

   // Compare a count
   task automatic chkn(input int a, input int e);
      num_checks++;
      if (a != e) begin
         bad_count++;
         $display("mismatch at %0t: count %0d expected %0d", $time, a, e);
      end
   endtask

   // One-cycle strobe; returns once the answer has landed
   task automatic pulse(input logic [7:0] m);
      @(negedge CLK);
      stb = m;
      @(negedge CLK);
      stb = 8'h00;
      @(negedge CLK);
   endtask

   task automatic ctrl(input logic h, input logic l, input logic src, input logic [2:0] s);
      mode_hi = h;
      mode_lo = l;
      clk_src = src;
      pre_sel = s;
      pulse(W_CTRL);
   endtask

   // Load, start and finish one frame with the peer
   task automatic run(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] ptx,
                      input int n, input logic ext, input int ex);
      int k;
      wr_data = lo;
      pulse(W_LOW);
      wr_data = hi;
      pulse(W_HIGH);
      peer.arm(ptx, n, ext, ex);
      rises = 0;
      pulse(W_START);
      chkv(busy, 1'b1);
      k = 0;
      while (peer.armed === 1'b1 && k < 5000) begin
         @(negedge CLK);
         k++;
      end
      chkn(k < 5000, 1);
      chkv(busy, 1'b0);
   endtask

   // Continuous clock period for every divisor
   task automatic t_prescale;
      int c;
      for (int s = 0; s < 8; s++) begin
         ctrl(1'b1, 1'b0, 1'b0, s[2:0]);
         c = 0;
         while (sck_w !== 1'b0 && c < 3000) begin
            @(negedge CLK);
            c++;
         end
         while (sck_w !== 1'b1 && c < 3000) begin
            @(negedge CLK);
            c++;
         end
         c = 0;
         do begin
            @(negedge CLK);
            c++;
         end while (sck_w !== 1'b0 && c < 3000);
         while (sck_w !== 1'b1 && c < 3000) begin
            @(negedge CLK);
            c++;
         end
         chkn(c, DIVS[s]);
      end
   endtask

   // Internal clock, both lengths, interrupt gating
   task automatic t_internal;
      ctrl(1'b0, 1'b0, 1'b0, 3'h4);
      run(8'hA5, 8'h00, 16'h003C, 8, 1'b0, 0);
      chkv(low_b, 8'h3C);
      chkv(peer.rx_word, 16'h00A5);
      chkn(rises, 8);
      chkv(done_req, 1'b1);
      chkv(irq, 1'b0);
      irq_en = 1'b1;
      @(negedge CLK);
      chkv(irq, 1'b1);
      repeat (40) @(negedge CLK);
      chkv(so_w, 1'b1);
      chkn(rises, 8);
      pulse(W_DCLR);
      chkv(done_req, 1'b0);
      irq_en = 1'b0;
      ctrl(1'b0, 1'b1, 1'b0, 3'h4);
      run(8'h34, 8'h12, 16'hBEEF, 16, 1'b0, 0);
      chkv({high_b, low_b}, 16'hBEEF);
      chkv(peer.rx_word, 16'h1234);
      chkn(rises, 16);
      chkv(so_w, 1'b0);
      pulse(W_DCLR);
   endtask

   // External clock with one extra pulse after the frame
   task automatic t_external;
      ctrl(1'b0, 1'b0, 1'b1, 3'h0);
      chkv(sck_oe_n, 1'b1);
      run(8'h5A, 8'h00, 16'h00C3, 8, 1'b1, 1);
      chkv(low_b, 8'hC3);
      chkv(peer.rx_word, 16'h005A);
      chkv(ovr, 1'b1);
      pulse(W_OCLR);
      chkv(ovr, 1'b1);
      pulse(W_ORD);
      pulse(W_OCLR);
      chkv(ovr, 1'b0);
      pulse(W_DCLR);
   endtask

   // Idle level, pin functions, abort and refused start
   task automatic t_misc;
      ctrl(1'b0, 1'b0, 1'b0, 3'h0);
      idle_data = 1'b1;
      pulse(W_IDLE);
      chkv({idle_bit, so_w}, 2'h3);
      idle_data = 1'b0;
      pulse(W_IDLE);
      chkv({idle_bit, so_w}, 2'h0);
      od_sel  = 1'b1;
      @(negedge CLK);
      chkv(so_oe_n, 1'b0);
      idle_data = 1'b1;
      pulse(W_IDLE);
      chkv(so_oe_n, 1'b1);
      od_sel  = 1'b0;
      pin_out = 1'b0;
      pin_ck  = 1'b0;
      @(negedge CLK);
      chkv({sck_oe_n, so_oe_n}, 2'h3);
      pin_out = 1'b1;
      pin_ck  = 1'b1;
      pulse(W_START);
      chkv(busy, 1'b1);
      ctrl(1'b0, 1'b0, 1'b0, 3'h4);
      chkv(busy, 1'b0);
      ctrl(1'b1, 1'b0, 1'b0, 3'h4);
      pulse(W_START);
      chkv(busy, 1'b0);
      ctrl(1'b0, 1'b0, 1'b0, 3'h4);
      run(8'h81, 8'h00, 16'h0066, 8, 1'b0, 0);
      chkv(low_b, 8'h66);
      chkn(rises, 8);
      // Data-in pin not selected: device must read idle high, not the peer
      pin_in = 1'b0;
      run(8'h00, 8'h00, 16'h0000, 8, 1'b0, 0);
      chkv(low_b, 8'hFF);
      pin_in = 1'b1;
   endtask

   // Hang guard
   initial begin
      repeat (40000) @(posedge CLK);
      bad_count++;
      $display("mismatch at %0t: run timed out", $time);
      complete_run;
   end

   // Main sequence
   initial begin
      repeat (5) @(negedge CLK);
      RESET_N = 1'b1;
      repeat (4) @(negedge CLK);
      chkv({busy, ovr, done_req, sck_o, sck_oe_n}, 5'h02);
      chkv({high_b, low_b}, 16'h0000);
      t_prescale;
      t_internal;
      t_external;
      t_misc;
      complete_run;
   end
endmodule
